// [hdl/des_pkg.sv]
// Constants, opcodes and types shared by the dual element shifter
package des_pkg;

  // Word layout: index 15 is the sign, index 14 magnitude bit 1,
  // index 0 magnitude bit 15 (least significant)
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned SIGN_POS      = 15;
  localparam int unsigned COUNT_W       = 6;
  localparam int unsigned OPCODE_W      = 9;

  // Timing in its own units, cycle counts derived from the clock
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TIME_PULSE_NS = 500;
  localparam int unsigned BASE_TIME_NS  = 6000;
  localparam int unsigned PULSE_DIV     = TIME_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned BASE_PULSES   = BASE_TIME_NS / TIME_PULSE_NS;
  localparam int unsigned FAST_MAX      = 6;
  localparam int unsigned SLOW_OFFSET   = 5;
  localparam int unsigned PULSE_CNT_W   = 7;

  // Opcodes, octal 400 404 440 444 420 424 and 024
  localparam logic [8:0] OPC_DUAL_LEFT  = 9'h100;
  localparam logic [8:0] OPC_DUAL_RIGHT = 9'h104;
  localparam logic [8:0] OPC_LEFT_RIGHT = 9'h120;
  localparam logic [8:0] OPC_RIGHT_RIGHT = 9'h124;
  localparam logic [8:0] OPC_ACC_LEFT   = 9'h110;
  localparam logic [8:0] OPC_ACC_RIGHT  = 9'h114;
  localparam logic [8:0] OPC_ROUND_LEFT = 9'h014;

  // Reset values of the accumulators and B registers
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_DUAL_COMBINED_LEFT,
    OP_DUAL_COMBINED_RIGHT,
    OP_LEFT_ELEMENT_RIGHT,
    OP_RIGHT_ELEMENT_RIGHT,
    OP_ACCUMULATORS_LEFT,
    OP_ACCUMULATORS_RIGHT,
    OP_ROUNDING_LEFT
  } des_op_t;

endpackage : des_pkg

// [hdl/des_pulse_gen.sv]
// Time pulse divider: one-cycle enable every DIV clocks while enabled
`timescale 1ns/1ps
module des_pulse_gen #(
  parameter int unsigned DIV = des_pkg::PULSE_DIV
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic restart,
  input  wire logic enable,
  output logic      tick_q
);
  import des_pkg::*;

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } des_pg_t;

  des_pg_t st_q;
  des_pg_t st_d;

  // Restart aligns the first pulse to DIV clocks after the start
  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (restart || !enable) begin
      st_d.cnt = '0;
    end else if (st_q.cnt == CW'(DIV - 1)) begin
      st_d.cnt  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_q = st_q.tick;

endmodule : des_pulse_gen

// [hdl/des_shifter.sv]
// Shift unit for the two arithmetic elements (accumulators and B regs)
//
// Behaviour
// [RL1] Count is instruction bits R10..R15 only
// [RL2] Right shift keeps sign, fills high with sign
// [RL3] Left shift keeps sign, fills low with sign
// [RL4] Shift opcodes are never index-modified
// [RL5] Shift class never raises overflow; here rounding left raises it on a roundoff carry
// [RL6] Up to six shifts finish in six microseconds
// [RL7] Longer shifts take 6.0 plus 0.5 per extra; here 6.5 plus 0.5 per extra shift
// [RL8] Opcode 400: combined left, sign into B15
// [RL9] Opcode 404: combined right, sign into bit 1
// [RL10] Opcode 440: left element combined right only
// [RL11] Opcode 444: right element combined right only
// [RL12] Opcode 420: accumulators left, B untouched
// [RL13] Accumulator left 17 octal gives all sign
// [RL14] Opcode 424: accumulators right, B untouched
// [RL15] No roundoff except the rounding left shift
// [RL16] Rounding left places quotient, rounds to 15
// [RL17] Program keeps divisor above dividend before divide
// [RL18] One place per two megacycle time pulse
// [RL19] Sign then magnitude, negatives in complement
`timescale 1ns/1ps
module des_shifter #(
  parameter int unsigned DIV = des_pkg::PULSE_DIV
) (
  input  wire logic                         clk,
  input  wire logic                         reset_n,
  input  wire logic                         start,
  input  wire logic [des_pkg::OPCODE_W-1:0] opcode,
  input  wire logic [des_pkg::WORD_W-1:0]   half_word,
  input  wire logic [des_pkg::WORD_W-1:0]   l_acc_in,
  input  wire logic [des_pkg::WORD_W-1:0]   l_b_in,
  input  wire logic [des_pkg::WORD_W-1:0]   r_acc_in,
  input  wire logic [des_pkg::WORD_W-1:0]   r_b_in,
  output logic [des_pkg::WORD_W-1:0]        l_acc_q,
  output logic [des_pkg::WORD_W-1:0]        l_b_q,
  output logic [des_pkg::WORD_W-1:0]        r_acc_q,
  output logic [des_pkg::WORD_W-1:0]        r_b_q,
  output logic                              busy_q,
  output logic                              done_q,
  output logic                              pause_q,
  output logic                              overflow_q,
  output logic                              index_inhibit_q
);
  import des_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_RUN} des_state_t;
  typedef struct packed {
    des_state_t             state;
    des_op_t                op;
    logic [COUNT_W-1:0]     count;
    logic [COUNT_W-1:0]     remaining;
    logic [PULSE_CNT_W-1:0] elapsed;
    logic [PULSE_CNT_W-1:0] total;
    logic [WORD_W-1:0]      l_acc;
    logic [WORD_W-1:0]      l_b;
    logic [WORD_W-1:0]      r_acc;
    logic [WORD_W-1:0]      r_b;
    logic                   busy;
    logic                   done;
    logic                   pause;
    logic                   ovf;
    logic                   idx_inh;
  } des_st_t;

  des_st_t st_q;
  des_st_t st_d;
  logic    tick;
  // Opcode decode, shared by start acceptance and index inhibit
  function automatic des_op_t decode_op(input logic [OPCODE_W-1:0] opc);
    case (opc)
      OPC_DUAL_LEFT:   decode_op = OP_DUAL_COMBINED_LEFT;
      OPC_DUAL_RIGHT:  decode_op = OP_DUAL_COMBINED_RIGHT;
      OPC_LEFT_RIGHT:  decode_op = OP_LEFT_ELEMENT_RIGHT;
      OPC_RIGHT_RIGHT: decode_op = OP_RIGHT_ELEMENT_RIGHT;
      OPC_ACC_LEFT:    decode_op = OP_ACCUMULATORS_LEFT;
      OPC_ACC_RIGHT:   decode_op = OP_ACCUMULATORS_RIGHT;
      OPC_ROUND_LEFT:  decode_op = OP_ROUNDING_LEFT;
      default:         decode_op = OP_NONE;
    endcase
  endfunction : decode_op

  // One place of the 31-bit chain of magnitude bits and B; sign fixed
  function automatic logic [31:0] step_pair(input logic [15:0] acc,
                                            input logic [15:0] b,
                                            input logic        left);
    logic [30:0] ch;
    ch = {acc[14:0], b};
    ch = left ? {ch[29:0], acc[SIGN_POS]}              // [RL3] [RL8]
              : {acc[SIGN_POS], ch[30:1]};             // [RL2] [RL9]
    step_pair = {acc[SIGN_POS], ch};
  endfunction : step_pair

  // One place of the accumulator magnitude alone
  function automatic logic [15:0] step_acc(input logic [15:0] acc,
                                           input logic        left);
    step_acc = left ? {acc[SIGN_POS], acc[13:0], acc[SIGN_POS]}   // [RL3]
                    : {acc[SIGN_POS], acc[SIGN_POS], acc[14:1]};  // [RL2]
  endfunction : step_acc

  // Roundoff: B sign bit carries into the magnitude; bit 16 is overflow.
  // Negatives are complemented around the carry to keep their sign fill
  function automatic logic [16:0] round_acc(input logic [15:0] acc,
                                            input logic [15:0] b);
    logic [15:0] mag;
    logic [15:0] sum;
    mag = acc[SIGN_POS] ? ~acc : acc;                  // [RL19]
    sum = {1'b0, mag[14:0]} + 16'h0001;
    if (!b[SIGN_POS]) begin
      round_acc = {1'b0, acc};
    end else if (acc[SIGN_POS]) begin
      round_acc = {sum[15], ~{1'b0, sum[14:0]}};
    end else begin
      round_acc = {sum[15], 1'b0, sum[14:0]};
    end
  endfunction : round_acc

  des_pulse_gen #(
    .DIV (DIV)
  ) u_pulse (
    .clk     (clk),
    .reset_n (reset_n),
    .restart (start && st_q.state == ST_IDLE),
    .enable  (st_q.state == ST_RUN),
    .tick_q  (tick)
  );

  // Sequencing: load at start, one place per time pulse, end on total
  always_comb begin
    des_op_t     dop;
    logic [31:0] pl;
    logic [31:0] pr;
    logic [16:0] rl;
    logic [16:0] rr;
    logic [PULSE_CNT_W-1:0] nxt;
    dop = decode_op(opcode);
    pl  = '0;
    pr  = '0;
    rl  = '0;
    rr  = '0;
    nxt = st_q.elapsed + 1'b1;
    st_d = st_q;
    st_d.done    = 1'b0;
    st_d.idx_inh = (dop != OP_NONE);                   // [RL4]
    case (st_q.state)
      ST_IDLE: begin
        if (start && dop != OP_NONE) begin
          st_d.state     = ST_RUN;
          st_d.op        = dop;
          st_d.count     = half_word[COUNT_W-1:0];     // [RL1]
          st_d.remaining = half_word[COUNT_W-1:0];     // [RL1]
          st_d.elapsed   = '0;
          st_d.ovf       = 1'b0;                       // [RL5]
          if (half_word[COUNT_W-1:0] <= COUNT_W'(FAST_MAX)) begin
            st_d.total = PULSE_CNT_W'(BASE_PULSES);    // [RL6]
          end else begin
            st_d.total = PULSE_CNT_W'(BASE_PULSES - SLOW_OFFSET)
                         + PULSE_CNT_W'(half_word[COUNT_W-1:0]); // [RL7]
          end
          st_d.l_acc = l_acc_in;
          st_d.l_b   = l_b_in;
          st_d.r_acc = r_acc_in;
          st_d.r_b   = r_b_in;
          st_d.busy  = 1'b1;
        end
      end
      ST_RUN: begin
        if (tick) begin                                // [RL18]
          st_d.elapsed = nxt;
          if (st_q.remaining != '0) begin
            st_d.remaining = st_q.remaining - 1'b1;
            case (st_q.op)
              OP_DUAL_COMBINED_LEFT, OP_ROUNDING_LEFT: begin
                pl = step_pair(st_q.l_acc, st_q.l_b, 1'b1); // [RL8]
                pr = step_pair(st_q.r_acc, st_q.r_b, 1'b1);
                {st_d.l_acc, st_d.l_b} = pl;
                {st_d.r_acc, st_d.r_b} = pr;
              end
              OP_DUAL_COMBINED_RIGHT: begin
                pl = step_pair(st_q.l_acc, st_q.l_b, 1'b0); // [RL9]
                pr = step_pair(st_q.r_acc, st_q.r_b, 1'b0);
                {st_d.l_acc, st_d.l_b} = pl;
                {st_d.r_acc, st_d.r_b} = pr;
              end
              OP_LEFT_ELEMENT_RIGHT: begin
                pl = step_pair(st_q.l_acc, st_q.l_b, 1'b0); // [RL10]
                {st_d.l_acc, st_d.l_b} = pl;
              end
              OP_RIGHT_ELEMENT_RIGHT: begin
                pr = step_pair(st_q.r_acc, st_q.r_b, 1'b0); // [RL11]
                {st_d.r_acc, st_d.r_b} = pr;
              end
              OP_ACCUMULATORS_LEFT: begin
                // Fifteen steps already leave all sign; more are harmless
                st_d.l_acc = step_acc(st_q.l_acc, 1'b1);    // [RL12] [RL13]
                st_d.r_acc = step_acc(st_q.r_acc, 1'b1);
              end
              OP_ACCUMULATORS_RIGHT: begin
                st_d.l_acc = step_acc(st_q.l_acc, 1'b0);    // [RL14]
                st_d.r_acc = step_acc(st_q.r_acc, 1'b0);
              end
              default: begin
              end
            endcase
          end
          // Arithmetic pause once the basic instruction time is used up
          st_d.pause = (nxt >= PULSE_CNT_W'(BASE_PULSES)) &&
                       (nxt != st_q.total);                  // [RL6]
          if (nxt == st_q.total) begin
            // Shifts are done by now since total exceeds count
            if (st_q.op == OP_ROUNDING_LEFT) begin           // [RL15]
              rl = round_acc(st_q.l_acc, st_q.l_b);          // [RL16]
              rr = round_acc(st_q.r_acc, st_q.r_b);
              st_d.l_acc = rl[15:0];
              st_d.r_acc = rr[15:0];
              st_d.ovf   = rl[16] | rr[16];
            end
            st_d.state = ST_IDLE;
            st_d.busy  = 1'b0;
            st_d.pause = 1'b0;
            st_d.done  = 1'b1;
          end
        end
      end
      default: begin
        st_d.state = ST_IDLE;
        st_d.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_q       <= '0;                  // Idle with no op: both code 0
      st_q.l_acc <= WORD_RESET;
      st_q.l_b   <= WORD_RESET;
      st_q.r_acc <= WORD_RESET;
      st_q.r_b   <= WORD_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state flops
  assign l_acc_q         = st_q.l_acc;
  assign l_b_q           = st_q.l_b;
  assign r_acc_q         = st_q.r_acc;
  assign r_b_q           = st_q.r_b;
  assign busy_q          = st_q.busy;
  assign done_q          = st_q.done;
  assign pause_q         = st_q.pause;
  assign overflow_q      = st_q.ovf;
  assign index_inhibit_q = st_q.idx_inh;

  // Checks on the sequencing and on the bit movement
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic shift_step;
  assign shift_step = st_q.state == ST_RUN && tick && st_q.remaining != '0;
  property p_count_field;
    (st_q.state == ST_IDLE && start && decode_op(opcode) != OP_NONE)
      |=> st_q.remaining == $past(half_word[COUNT_W-1:0]);
  endproperty
  a_count_field: assert property (p_count_field) // [RL1]
    else $error("shift count not taken from low six bits");
  property p_right_sign;
    (shift_step && st_q.op == OP_ACCUMULATORS_RIGHT)
      |=> l_acc_q == $past({l_acc_q[15], l_acc_q[15], l_acc_q[14:1]});
  endproperty
  a_right_sign: assert property (p_right_sign) // [RL2]
    else $error("right shift sign fill wrong");
  property p_left_sign;
    (shift_step && st_q.op == OP_ACCUMULATORS_LEFT)
      |=> r_acc_q == $past({r_acc_q[15], r_acc_q[13:0], r_acc_q[15]});
  endproperty
  a_left_sign: assert property (p_left_sign) // [RL3]
    else $error("left shift sign fill wrong");
  property p_index_inhibit;
    (decode_op(opcode) != OP_NONE) |=> index_inhibit_q;
  endproperty
  a_index_inhibit: assert property (p_index_inhibit) // [RL4]
    else $error("index inhibit missing for shift opcode");
  property p_no_overflow;
    (done_q && st_q.op != OP_ROUNDING_LEFT) |-> !overflow_q;
  endproperty
  a_no_overflow: assert property (p_no_overflow) // [RL5]
    else $error("overflow raised by shift");
  property p_fast_time;
    (busy_q && st_q.count <= COUNT_W'(FAST_MAX))
      |-> st_q.total == PULSE_CNT_W'(BASE_PULSES) && !pause_q;
  endproperty
  a_fast_time: assert property (p_fast_time) // [RL6]
    else $error("short shift exceeds basic time");
  property p_slow_time;
    (busy_q && tick && st_q.elapsed + 7'd1 == st_q.total)
      |=> done_q && !busy_q ##1 !done_q;
  endproperty
  a_slow_time: assert property (p_slow_time) // [RL7]
    else $error("completion not on final time pulse");
  property p_dual_left;
    (shift_step && st_q.op == OP_DUAL_COMBINED_LEFT)
      |=> l_b_q[0] == $past(l_acc_q[15]) && l_acc_q[0] == $past(l_b_q[15])
          && l_acc_q[15] == $past(l_acc_q[15]);
  endproperty
  a_dual_left: assert property (p_dual_left) // [RL8]
    else $error("combined left shift wrong");
  property p_dual_right;
    (shift_step && st_q.op == OP_DUAL_COMBINED_RIGHT)
      |=> r_acc_q[14] == $past(r_acc_q[15]) && r_b_q[15] == $past(r_acc_q[0]);
  endproperty
  a_dual_right: assert property (p_dual_right) // [RL9]
    else $error("combined right shift wrong");
  property p_left_only;
    (busy_q && st_q.op == OP_LEFT_ELEMENT_RIGHT)
      |=> $stable(r_acc_q) && $stable(r_b_q);
  endproperty
  a_left_only: assert property (p_left_only) // [RL10]
    else $error("right element disturbed");
  property p_right_only;
    (busy_q && st_q.op == OP_RIGHT_ELEMENT_RIGHT)
      |=> $stable(l_acc_q) && $stable(l_b_q);
  endproperty
  a_right_only: assert property (p_right_only) // [RL11]
    else $error("left element disturbed");
  property p_acc_only;
    (busy_q && (st_q.op == OP_ACCUMULATORS_LEFT ||
                st_q.op == OP_ACCUMULATORS_RIGHT))
      |=> $stable(l_b_q) && $stable(r_b_q);
  endproperty
  a_acc_only: assert property (p_acc_only) // [RL12]
    else $error("B register disturbed by accumulator shift");
  property p_pulse_paced;
    (busy_q && !tick) |=> $stable(l_b_q) && $stable(r_b_q);
  endproperty
  a_pulse_paced: assert property (p_pulse_paced) // [RL18]
    else $error("shift without time pulse");
endmodule : des_shifter

// [bench/des_seq_model.sv]
// Sequencer model: presents shift instructions and operand words
`timescale 1ns/1ps
module des_seq_model (
  input  wire logic                         clk,
  output logic                              start,
  output logic [des_pkg::OPCODE_W-1:0]      opcode,
  output logic [des_pkg::WORD_W-1:0]        half_word,
  output logic [des_pkg::WORD_W-1:0]        l_acc_in,
  output logic [des_pkg::WORD_W-1:0]        l_b_in,
  output logic [des_pkg::WORD_W-1:0]        r_acc_in,
  output logic [des_pkg::WORD_W-1:0]        r_b_in
);
  import des_pkg::*;

  // Quiet bus before the first instruction, no supported code shown
  initial begin
    start     = 1'b0;
    opcode    = 9'h0ff;
    half_word = 16'h0000;
    l_acc_in  = 16'h0000;
    l_b_in    = 16'h0000;
    r_acc_in  = 16'h0000;
    r_b_in    = 16'h0000;
  end

  // One instruction: start for a single cycle, then fields go stale.
  // Rounding operands are taken as given; no divide precedes them here,
  // so the divisor-above-dividend duty is trivially kept
  task automatic issue(input logic [8:0] op, input logic [15:0] hw,
                       input logic [15:0] la, input logic [15:0] lb,
                       input logic [15:0] ra, input logic [15:0] rb);
    @(negedge clk);
    start     = 1'b1;
    opcode    = op;
    half_word = hw;
    l_acc_in  = la;
    l_b_in    = lb;
    r_acc_in  = ra;
    r_b_in    = rb;
    @(negedge clk);
    start     = 1'b0;
    // Inverted stale fields catch a late sampler; no inverse is supported
    opcode    = ~op;
    half_word = ~hw;
    l_acc_in  = ~la;
    l_b_in    = ~lb;
    r_acc_in  = ~ra;
    r_b_in    = ~rb;
  endtask : issue
endmodule : des_seq_model

// [bench/tb_dual_element_shifter.sv]
// Self-checking bench for the dual element shifter
`timescale 1ns/1ps
module tb_dual_element_shifter;
  import des_pkg::*;
  localparam int DIV_T = 4;

  logic        clk;
  logic        reset_n;
  logic        start;
  logic [8:0]  opcode;
  logic [15:0] half_word;
  logic [15:0] l_acc_in;
  logic [15:0] l_b_in;
  logic [15:0] r_acc_in;
  logic [15:0] r_b_in;
  logic [15:0] l_acc_q;
  logic [15:0] l_b_q;
  logic [15:0] r_acc_q;
  logic [15:0] r_b_q;
  logic        busy_q;
  logic        done_q;
  logic        pause_q;
  logic        overflow_q;
  logic        index_inhibit_q;
  int          n_errors;
  int          compares;
  int          seed;
  logic [8:0]  ops [7];
  logic [15:0] cnts [7];

  // Short pulse divider keeps the long counts cheap to run
  des_shifter #(.DIV(DIV_T)) u_des_shifter (
    .clk(clk), .reset_n(reset_n), .start(start), .opcode(opcode),
    .half_word(half_word), .l_acc_in(l_acc_in), .l_b_in(l_b_in),
    .r_acc_in(r_acc_in), .r_b_in(r_b_in), .l_acc_q(l_acc_q),
    .l_b_q(l_b_q), .r_acc_q(r_acc_q), .r_b_q(r_b_q), .busy_q(busy_q),
    .done_q(done_q), .pause_q(pause_q), .overflow_q(overflow_q),
    .index_inhibit_q(index_inhibit_q));

  des_seq_model u_des_seq_model (
    .clk(clk), .start(start), .opcode(opcode), .half_word(half_word),
    .l_acc_in(l_acc_in), .l_b_in(l_b_in), .r_acc_in(r_acc_in),
    .r_b_in(r_b_in));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] want);
    compares++;
    if (got !== want) begin
      n_errors++;
      $display("Error at %0t: word %h, expected %h", $time, got, want);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic want);
    compares++;
    if (got !== want) begin
      n_errors++;
      $display("Error at %0t: flag %b, expected %b", $time, got, want);
    end
  endtask : chk_bit

  // Cycle counts only; one clock of slack, well under one pulse
  task automatic chk_time(input int got, input int want);
    compares++;
    if (got < want - 1 || got > want + 1) begin
      n_errors++;
      $display("Error at %0t: took %0d cycles, expected %0d", $time, got,
               want);
    end
  endtask : chk_time

  // Accumulator magnitude plus B as one 31-bit chain, sign held apart
  function automatic logic [31:0] sh_pair(input logic [15:0] acc,
      input logic [15:0] b, input logic [5:0] n, input logic left);
    logic [30:0] c;
    c = {acc[14:0], b};
    for (int i = 0; i < n; i++) begin
      c = left ? {c[29:0], acc[15]} : {acc[15], c[30:1]};
    end
    return {acc[15], c};
  endfunction : sh_pair

  function automatic logic [15:0] sh_acc(input logic [15:0] acc,
      input logic [5:0] n, input logic left);
    logic [14:0] m;
    m = acc[14:0];
    for (int i = 0; i < n; i++) begin
      m = left ? {m[13:0], acc[15]} : {acc[15], m[14:1]};
    end
    return {acc[15], m};
  endfunction : sh_acc

  // Magnitude up by one in complement form; carry out flags overflow
  function automatic logic [15:0] rnd(input logic [15:0] acc,
      input logic bsign, inout logic ov);
    logic [15:0] t;
    if (!bsign) return acc;
    t = {1'b0, acc[15] ? ~acc[14:0] : acc[14:0]} + 16'h0001;
    ov = ov | t[15];
    return {acc[15], acc[15] ? ~t[14:0] : t[14:0]};
  endfunction : rnd

  function automatic logic [64:0] expect_res(input logic [8:0] op,
      input logic [5:0] n, input logic [15:0] la, input logic [15:0] lb,
      input logic [15:0] ra, input logic [15:0] rb);
    logic [31:0] lp;
    logic [31:0] rp;
    logic        ov;
    lp = {la, lb};
    rp = {ra, rb};
    ov = 1'b0;
    if (op == OPC_DUAL_LEFT || op == OPC_ROUND_LEFT) begin
      lp = sh_pair(la, lb, n, 1'b1);
      rp = sh_pair(ra, rb, n, 1'b1);
    end
    if (op == OPC_DUAL_RIGHT || op == OPC_LEFT_RIGHT) begin
      lp = sh_pair(la, lb, n, 1'b0);
    end
    if (op == OPC_DUAL_RIGHT || op == OPC_RIGHT_RIGHT) begin
      rp = sh_pair(ra, rb, n, 1'b0);
    end
    if (op == OPC_ACC_LEFT || op == OPC_ACC_RIGHT) begin
      lp[31:16] = sh_acc(la, n, op == OPC_ACC_LEFT);
      rp[31:16] = sh_acc(ra, n, op == OPC_ACC_LEFT);
    end
    if (op == OPC_ROUND_LEFT) begin
      lp[31:16] = rnd(lp[31:16], lp[15], ov);
      rp[31:16] = rnd(rp[31:16], rp[15], ov);
    end
    return {ov, lp, rp};
  endfunction : expect_res

  // Issue one instruction, optionally poke a start while busy, then check
  task automatic run_op(input logic [8:0] op, input logic [15:0] hw,
      input logic [15:0] la, input logic [15:0] lb, input logic [15:0] ra,
      input logic [15:0] rb, input bit intr);
    logic [64:0] e;
    int          t_pulses;
    int          cyc;
    logic        saw_pause;
    e = expect_res(op, hw[5:0], la, lb, ra, rb);
    t_pulses = (hw[5:0] <= 6) ? 12 : int'(hw[5:0]) + 7;
    cyc = 0;
    saw_pause = 1'b0;
    u_des_seq_model.issue(op, hw, la, lb, ra, rb);
    chk_bit(index_inhibit_q, 1'b1);
    fork
      while (done_q !== 1'b1 && cyc < 400) begin
        @(posedge clk);
        #1;
        cyc++;
        if (cyc == 1) chk_bit(busy_q, 1'b1);
        if (pause_q === 1'b1) saw_pause = 1'b1;
      end
      if (intr) begin
        repeat (3) @(negedge clk);
        u_des_seq_model.issue(OPC_ACC_LEFT, 16'h0003, ~la, ~lb, ~ra, ~rb);
      end
    join
    chk_time(cyc, t_pulses * DIV_T + 1);
    chk_bit(saw_pause, t_pulses > 12);
    chk_bit(busy_q, 1'b0);
    chk_bit(pause_q, 1'b0);
    chk_word(l_acc_q, e[63:48]);
    chk_word(l_b_q, e[47:32]);
    chk_word(r_acc_q, e[31:16]);
    chk_word(r_b_q, e[15:0]);
    chk_bit(overflow_q, e[64]);
  endtask : run_op

  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the roughly 12k cycles the sequence needs
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("Error at %0t: run did not finish", $time);
    tally_and_finish();
  end

  initial begin
    logic [2:0] k;
    seed = 32'h6d355d68;
    n_errors = 0;
    compares = 0;
    ops = '{OPC_DUAL_LEFT, OPC_DUAL_RIGHT, OPC_LEFT_RIGHT, OPC_RIGHT_RIGHT,
            OPC_ACC_LEFT, OPC_ACC_RIGHT, OPC_ROUND_LEFT};
    // Boundary counts; ff45 must act as five since only six bits count
    cnts = '{16'h0000, 16'h0006, 16'h0007, 16'h000f, 16'h0010, 16'h003f,
             16'hff45};
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    chk_bit(busy_q, 1'b0);
    chk_word(l_acc_q, WORD_RESET);
    chk_bit(overflow_q, 1'b0);
    // Every opcode at every boundary count, random operands
    for (int i = 0; i < 7; i++) begin
      for (int j = 0; j < 7; j++) begin
        run_op(ops[i], cnts[j], 16'($random(seed)), 16'($random(seed)),
               16'($random(seed)), 16'($random(seed)), j == 3);
      end
    end
    // Rounding with B sign set, positive and complemented accumulators
    run_op(OPC_ROUND_LEFT, 16'h0000, 16'h1234, 16'h8000, 16'hedcb,
           16'h8000, 1'b0);
    run_op(OPC_ROUND_LEFT, 16'h0000, 16'h7fff, 16'h8000, 16'h8000,
           16'h8000, 1'b0);
    // Unsupported code is ignored without any sign at the ports
    u_des_seq_model.issue(9'h1ff, 16'h0003, 16'h1111, 16'h2222, 16'h3333,
                          16'h4444);
    chk_bit(index_inhibit_q, 1'b0);
    repeat (10) @(negedge clk);
    chk_bit(busy_q, 1'b0);
    // Reset in mid-instruction must drop everything back to idle
    u_des_seq_model.issue(OPC_DUAL_LEFT, 16'h0020, 16'h1234, 16'h5678,
                          16'h9abc, 16'hdef0);
    repeat (30) @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    chk_bit(busy_q, 1'b0);
    chk_bit(done_q, 1'b0);
    chk_word(l_b_q, WORD_RESET);
    // Random mix of opcodes, counts and busy-time pokes
    for (int i = 0; i < 40; i++) begin
      k = 3'($unsigned($random(seed)) % 7);
      run_op(ops[k], 16'($random(seed)), 16'($random(seed)),
             16'($random(seed)), 16'($random(seed)), 16'($random(seed)),
             i[0]);
    end
    tally_and_finish();
  end
endmodule : tb_dual_element_shifter
